// ---- fesp_pkg.sv ----
// Purpose: Shared constants for the flash erase status and program value block
// Assumes: 16-bit register port, byte addresses as printed
// Notes:   Offsets not printed are placed beside the printed ones
package fesp_pkg;
    localparam int          FESP_ADDR_W         = 24;
    localparam int          FESP_DATA_W         = 16;
    localparam int          FESP_BANKS          = 4;
    localparam int          FESP_SECT_PER_BANK  = 2;
    localparam int          FESP_SECTS          = FESP_BANKS * FESP_SECT_PER_BANK;

    localparam logic [23:0] FESP_OFS_STATUS_HIGH = 24'h0e0006;
    localparam logic [23:0] FESP_OFS_P0_LOW      = 24'h0e0008;
    localparam logic [23:0] FESP_OFS_P0_HIGH     = 24'h0e000a;
    localparam logic [23:0] FESP_OFS_P1_LOW      = 24'h0e000c;
    localparam logic [23:0] FESP_OFS_P1_HIGH     = 24'h0e000e;
    localparam logic [23:0] FESP_OFS_CONTROL     = 24'h0e0020;
    localparam logic [23:0] FESP_OFS_FAULT       = 24'h0e0022;
    localparam logic [23:0] FESP_OFS_IRQ_STATUS  = 24'h0e0024;
    localparam logic [23:0] FESP_OFS_IRQ_MASK    = 24'h0e0026;

    localparam logic [15:0] FESP_RST_STATUS_HIGH = 16'h0000;
    localparam logic [15:0] FESP_RST_P1_LOW      = 16'hffff;
    localparam logic [15:0] FESP_RST_OTHER_DATA  = 16'hffff;
    localparam logic [15:0] FESP_RST_ZERO        = 16'h0000;

    // Field positions
    localparam int          FESP_BIT_SECT_LO    = 0;
    localparam int          FESP_BIT_BANK_LO    = 8;
    localparam int          FESP_BIT_ARRAY_SEL  = 0;
    localparam int          FESP_BIT_LAUNCH     = 1;
    localparam int          FESP_BIT_PAUSED     = 2;
    localparam int          FESP_BIT_FAULT      = 0;
    localparam int          FESP_IRQ_W          = 3;
    localparam int          FESP_IRQ_DONE       = 0;
    localparam int          FESP_IRQ_FAULT      = 1;
    localparam int          FESP_IRQ_REFUSED    = 2;

    typedef enum logic [2:0] {
        FESP_MEAN_NONE    = 3'b001,
        FESP_MEAN_SUSPEND = 3'b010,
        FESP_MEAN_ERROR   = 3'b100
    } fesp_meaning_type;
endpackage : fesp_pkg

// ---- fesp_stat_if.sv ----
// Purpose: Carries status events and flags between top and tracker
// Assumes: Same clock on both sides
// Notes:   None
`timescale 1ns/1ps
interface fesp_stat_if;
    import fesp_pkg::*;
    logic                     mark;
    logic [1:0]               mark_bank;
    logic                     mark_sect;
    logic                     clear_all;
    logic [FESP_SECTS-1:0]    sect_flags;
    logic [FESP_BANKS-1:0]    bank_flags;

    modport top (output mark, output mark_bank, output mark_sect, output clear_all,
                 input sect_flags, input bank_flags);
    modport trk (input mark, input mark_bank, input mark_sect, input clear_all,
                 output sect_flags, output bank_flags);
endinterface : fesp_stat_if

// ---- fesp_status.sv ----
// Purpose: Sector and bank status flags kept during erase
// Assumes: Marks arrive only while an erase runs
// Notes:   A mark in the clearing cycle survives
`timescale 1ns/1ps
module fesp_status
    import fesp_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    fesp_stat_if.trk   st
);
    logic [FESP_SECTS-1:0] sect_ff;
    logic [FESP_SECTS-1:0] nxt_sect;
    logic [FESP_SECTS-1:0] hit;

    genvar g;
    generate
        for (g = 0; g < FESP_SECTS; g++) begin : g_sect
            assign hit[g] = st.mark && ({st.mark_bank, st.mark_sect} == 3'(g));
        end
        for (g = 0; g < FESP_BANKS; g++) begin : g_bank
            assign st.bank_flags[g] = |sect_ff[g*2 +: 2];
        end
    endgenerate

    // Set beats clear so a late mark is never lost
    assign nxt_sect = (st.clear_all ? '0 : sect_ff) | hit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sect_ff <= '0;
        end else begin
            sect_ff <= nxt_sect;
        end
    end

    assign st.sect_flags = sect_ff;
endmodule : fesp_status

// ---- fesp_top.sv ----
// Purpose: Erase status reporting and program value registers
// Assumes: Controller signals share clk; register port is 16 bits
// Notes:   Read data appear the cycle after the read strobe
`timescale 1ns/1ps
module fesp_top
    import fesp_pkg::*;
#(
    parameter int ADDR_W = FESP_ADDR_W
)(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic [FESP_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [FESP_DATA_W-1:0] reg_rdata,
    input  wire logic                   erase_mark,
    input  wire logic [1:0]             erase_mark_bank,
    input  wire logic                   erase_mark_sector,
    input  wire logic                   erase_done,
    input  wire logic                   write_error,
    input  wire logic                   setup_error,
    input  wire logic                   paused_flag,
    output logic                        write_launch,
    output logic [63:0]                 program_value,
    output fesp_meaning_type            flag_meaning,
    output logic                        irq
);
    // Offsets are 24 bits wide; a narrower bus would alias registers
    if (ADDR_W < FESP_ADDR_W) begin : g_addr_w_check
        $error("fesp_top: ADDR_W must hold 24-bit offsets");
    end

    logic [15:0]           p0_low_ff;
    logic [15:0]           p0_high_ff;
    logic [15:0]           p1_low_ff;
    logic [15:0]           p1_high_ff;
    logic                  array_sel_ff;
    logic                  fault_ff;
    logic                  launch_ff;
    logic [FESP_IRQ_W-1:0] irq_stat_ff;
    logic [FESP_IRQ_W-1:0] irq_mask_ff;
    logic [15:0]           rdata_ff;
    logic                  irq_ff;
    fesp_meaning_type      meaning_ff;

    fesp_stat_if st ();

    fesp_status u_status (
        .clk   (clk),
        .rst_n (rst_n),
        .st    (st.trk)
    );

    // Address decode
    function automatic logic hit_at(input logic [ADDR_W-1:0] a, input logic [23:0] ofs);
        hit_at = (a == ADDR_W'(ofs));
    endfunction : hit_at

    wire sel_status   = hit_at(reg_addr, FESP_OFS_STATUS_HIGH);
    wire sel_p0_low   = hit_at(reg_addr, FESP_OFS_P0_LOW);
    wire sel_p0_high  = hit_at(reg_addr, FESP_OFS_P0_HIGH);
    wire sel_p1_low   = hit_at(reg_addr, FESP_OFS_P1_LOW);
    wire sel_p1_high  = hit_at(reg_addr, FESP_OFS_P1_HIGH);
    wire sel_control  = hit_at(reg_addr, FESP_OFS_CONTROL);
    wire sel_fault    = hit_at(reg_addr, FESP_OFS_FAULT);
    wire sel_irq_stat = hit_at(reg_addr, FESP_OFS_IRQ_STATUS);
    wire sel_irq_mask = hit_at(reg_addr, FESP_OFS_IRQ_MASK);

    wire wr_control   = reg_wr && sel_control;
    wire launch_req   = wr_control && reg_wdata[FESP_BIT_LAUNCH];
    // Start refused while faulted or suspended
    wire launch_ok    = launch_req && !fault_ff && !paused_flag;
    wire launch_bad   = launch_req && !launch_ok;
    wire fault_set    = write_error || setup_error;
    wire fault_clr    = reg_wr && sel_fault && reg_wdata[FESP_BIT_FAULT];
    wire clean_end    = erase_done && !fault_ff && !fault_set;

    assign st.mark      = erase_mark;
    assign st.mark_bank = erase_mark_bank;
    assign st.mark_sect = erase_mark_sector;
    assign st.clear_all = clean_end;

    // Status high view by array select
    wire [1:0] view_sect = array_sel_ff ? st.sect_flags[3:2] : st.sect_flags[7:6];
    wire [1:0] view_bank = array_sel_ff ? st.bank_flags[1:0] : st.bank_flags[3:2];
    wire [15:0] status_view = FESP_RST_STATUS_HIGH
                            | (16'(view_sect) << FESP_BIT_SECT_LO)
                            | (16'(view_bank) << FESP_BIT_BANK_LO);

    wire [15:0] control_view = 16'(array_sel_ff) << FESP_BIT_ARRAY_SEL
                             | 16'(paused_flag) << FESP_BIT_PAUSED;

    wire [15:0] rd_mux = sel_status   ? status_view :
                         sel_p0_low   ? p0_low_ff :
                         sel_p0_high  ? p0_high_ff :
                         sel_p1_low   ? p1_low_ff :
                         sel_p1_high  ? p1_high_ff :
                         sel_control  ? control_view :
                         sel_fault    ? 16'(fault_ff) :
                         sel_irq_stat ? 16'(irq_stat_ff) :
                         sel_irq_mask ? 16'(irq_mask_ff) :
                                        FESP_RST_ZERO;

    // Meaning of a set flag
    wire fesp_meaning_type nxt_meaning = fault_ff    ? FESP_MEAN_ERROR :
                                         paused_flag ? FESP_MEAN_SUSPEND :
                                                       FESP_MEAN_NONE;

    wire [FESP_IRQ_W-1:0] irq_evt = {launch_bad, fault_set, erase_done};
    wire [FESP_IRQ_W-1:0] irq_w1c = (reg_wr && sel_irq_stat) ? reg_wdata[FESP_IRQ_W-1:0] : '0;
    // Set wins over write-one-clear
    wire [FESP_IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_w1c) | irq_evt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p0_low_ff  <= FESP_RST_OTHER_DATA;
            p0_high_ff <= FESP_RST_OTHER_DATA;
            p1_low_ff  <= FESP_RST_P1_LOW;
            p1_high_ff <= FESP_RST_OTHER_DATA;
        end else if (reg_wr) begin
            if (sel_p0_low) p0_low_ff <= reg_wdata;
            if (sel_p0_high) p0_high_ff <= reg_wdata;
            if (sel_p1_low) p1_low_ff <= reg_wdata;
            if (sel_p1_high) p1_high_ff <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            array_sel_ff <= 1'b0;
            launch_ff    <= 1'b0;
            fault_ff     <= 1'b0;
        end else begin
            if (wr_control) array_sel_ff <= reg_wdata[FESP_BIT_ARRAY_SEL];
            launch_ff <= launch_ok;
            // Hardware set beats software clear
            fault_ff  <= fault_set | (fault_ff & ~fault_clr);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff      <= 1'b0;
            rdata_ff    <= FESP_RST_ZERO;
            meaning_ff  <= FESP_MEAN_NONE;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            if (reg_wr && sel_irq_mask) irq_mask_ff <= reg_wdata[FESP_IRQ_W-1:0];
            irq_ff      <= |(nxt_irq_stat & irq_mask_ff);
            rdata_ff    <= reg_rd ? rd_mux : FESP_RST_ZERO;
            meaning_ff  <= nxt_meaning;
        end
    end

    assign reg_rdata     = rdata_ff;
    assign write_launch  = launch_ff;
    // Flops only; pair 1 is the upper word
    assign program_value = {p1_high_ff, p1_low_ff, p0_high_ff, p0_low_ff};
    assign flag_meaning  = meaning_ff;
    assign irq           = irq_ff;
endmodule : fesp_top

// ---- fesp_top_monitor.sv ----
// Purpose: Port assertions for fesp_top
// Assumes: One clock domain, reset active low
// Notes:   Bound from the bench, sees ports only
`timescale 1ns/1ps
module fesp_top_monitor
    import fesp_pkg::*;
#(
    parameter int ADDR_W = FESP_ADDR_W
)(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [15:0]       reg_rdata,
    input wire logic              erase_mark,
    input wire logic [1:0]        erase_mark_bank,
    input wire logic              erase_mark_sector,
    input wire logic              erase_done,
    input wire logic              write_error,
    input wire logic              setup_error,
    input wire logic              paused_flag,
    input wire logic              write_launch,
    input wire logic [63:0]       program_value,
    input wire fesp_meaning_type  flag_meaning,
    input wire logic              irq
);
    logic launch_req;
    assign launch_req = reg_wr && reg_addr == FESP_OFS_CONTROL && reg_wdata[FESP_BIT_LAUNCH];
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    // A clear write right after the event hides the error meaning only one cycle after the check
    sequence s_err;
        (write_error || setup_error) ##1 !reg_wr;
    endsequence
    a_p0_low_load: assert property (s_wr(FESP_OFS_P0_LOW) |=> program_value[15:0] == $past(reg_wdata))
        else $error("pair 0 low not loaded");
    a_p1_high_load: assert property (s_wr(FESP_OFS_P1_HIGH) |=> program_value[63:48] == $past(reg_wdata))
        else $error("pair 1 high not loaded");
    a_value_hold: assert property (!reg_wr |=> $stable(program_value))
        else $error("program value moved without a write");
    a_p1_low_read: assert property (reg_rd && reg_addr == FESP_OFS_P1_LOW |=> reg_rdata == program_value[47:32])
        else $error("pair 1 low read wrong");
    a_status_spare_zero: assert property (reg_rd && reg_addr == FESP_OFS_STATUS_HIGH |=>
        reg_rdata[7:2] == 6'h00 && reg_rdata[15:10] == 6'h00)
        else $error("status spare bits set");
    a_error_meaning: assert property (s_err |=> flag_meaning == FESP_MEAN_ERROR)
        else $error("error meaning missing");
    a_suspend_cause: assert property (flag_meaning == FESP_MEAN_SUSPEND |-> $past(paused_flag))
        else $error("suspend meaning without pause");
    a_meaning_onehot: assert property ($onehot(flag_meaning))
        else $error("meaning not one-hot");
    a_launch_cause: assert property (write_launch |-> $past(launch_req) && !$past(paused_flag))
        else $error("launch without accepted start");
    a_launch_pulse: assert property (write_launch && !launch_req |=> !write_launch)
        else $error("launch longer than one cycle");
endmodule : fesp_top_monitor

// ---- tb_fesp_top.sv ----
// Purpose: Self-checking bench for fesp_top
// Assumes: Register port answers reads one cycle later
// Notes:   Inputs change by non-blocking assignment at posedge
`timescale 1ns/1ps
module tb_fesp_top;
    import fesp_pkg::*;
    logic             clk, rst_n, reg_wr, reg_rd, erase_mark, erase_mark_sector, erase_done;
    logic             write_error, setup_error, paused_flag, write_launch, irq;
    logic [23:0]      reg_addr;
    logic [15:0]      reg_wdata, reg_rdata;
    logic [1:0]       erase_mark_bank;
    logic [63:0]      program_value;
    fesp_meaning_type flag_meaning;
    int               err_total, comparisons;
    logic [23:0]      ofs[4] = '{FESP_OFS_P0_LOW, FESP_OFS_P0_HIGH, FESP_OFS_P1_LOW, FESP_OFS_P1_HIGH};
    logic [15:0]      dat[4] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0};
    fesp_top dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .erase_mark,
        .erase_mark_bank, .erase_mark_sector, .erase_done, .write_error, .setup_error, .paused_flag,
        .write_launch, .program_value, .flag_meaning, .irq);
    task chk(input string n, input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task wr(input logic [23:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [23:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk($sformatf("read %h", a), {48'h0, reg_rdata}, {48'h0, e});
    endtask : rd
    task mark(input logic [1:0] b, input logic s);
        @(posedge clk);
        erase_mark <= 1'b1;
        erase_mark_bank <= b;
        erase_mark_sector <= s;
        @(posedge clk);
        erase_mark <= 1'b0;
    endtask : mark
    // Event pulses: 0 done, 1 write error, 2 setup error
    task ev(input int k);
        @(posedge clk);
        {setup_error, write_error, erase_done} <= 3'(1 << k);
        @(posedge clk);
        {setup_error, write_error, erase_done} <= 3'h0;
    endtask : ev
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        tally_and_finish;
    end
    initial begin
        {rst_n, reg_wr, reg_rd, erase_mark, erase_mark_sector, erase_done} = 6'h00;
        {write_error, setup_error, paused_flag, erase_mark_bank} = 5'h00;
        reg_addr = 24'h000000;
        reg_wdata = 16'h0000;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("value", program_value, {4{16'hffff}});
        rd(FESP_OFS_STATUS_HIGH, 16'h0000);
        rd(FESP_OFS_P1_LOW, 16'hffff);
        $display("reset test done");
        foreach (ofs[i]) wr(ofs[i], dat[i]);
        @(negedge clk);
        chk("value", program_value, 64'hdef09abc56781234);
        foreach (ofs[i]) rd(ofs[i], dat[i]);
        wr(FESP_OFS_STATUS_HIGH, 16'hffff);
        rd(FESP_OFS_STATUS_HIGH, 16'h0000);
        rd(24'h0e0030, 16'h0000);
        $display("data test done");
        mark(2'h3, 1'b1);
        mark(2'h1, 1'b0);
        mark(2'h0, 1'b1);
        mark(2'h2, 1'b0);
        rd(FESP_OFS_STATUS_HIGH, 16'h0302);
        wr(FESP_OFS_CONTROL, 16'h0001);
        rd(FESP_OFS_STATUS_HIGH, 16'h0301);
        ev(0);
        rd(FESP_OFS_STATUS_HIGH, 16'h0000);
        wr(FESP_OFS_CONTROL, 16'h0000);
        rd(FESP_OFS_STATUS_HIGH, 16'h0000);
        $display("status test done");
        @(posedge clk);
        paused_flag <= 1'b1;
        mark(2'h3, 1'b0);
        repeat (2) @(negedge clk);
        chk("meaning", {61'h0, flag_meaning}, {61'h0, FESP_MEAN_SUSPEND});
        wr(FESP_OFS_CONTROL, 16'h0002);
        @(negedge clk);
        chk("launch", {63'h0, write_launch}, 64'h0);
        @(posedge clk);
        paused_flag <= 1'b0;
        ev(1);
        repeat (2) @(negedge clk);
        chk("meaning", {61'h0, flag_meaning}, {61'h0, FESP_MEAN_ERROR});
        ev(0);
        rd(FESP_OFS_STATUS_HIGH, 16'h0201);
        rd(FESP_OFS_FAULT, 16'h0001);
        wr(FESP_OFS_CONTROL, 16'h0002);
        @(negedge clk);
        chk("launch", {63'h0, write_launch}, 64'h0);
        wr(FESP_OFS_FAULT, 16'h0001);
        ev(2);
        rd(FESP_OFS_FAULT, 16'h0001);
        wr(FESP_OFS_FAULT, 16'h0001);
        rd(FESP_OFS_FAULT, 16'h0000);
        chk("meaning", {61'h0, flag_meaning}, {61'h0, FESP_MEAN_NONE});
        ev(0);
        rd(FESP_OFS_STATUS_HIGH, 16'h0000);
        wr(FESP_OFS_CONTROL, 16'h0002);
        @(negedge clk);
        chk("launch", {63'h0, write_launch}, 64'h1);
        $display("fault test done");
        chk("irq", {63'h0, irq}, 64'h0);
        rd(FESP_OFS_IRQ_STATUS, 16'h0007);
        wr(FESP_OFS_IRQ_MASK, 16'h0004);
        repeat (2) @(negedge clk);
        chk("irq", {63'h0, irq}, 64'h1);
        wr(FESP_OFS_IRQ_STATUS, 16'h0007);
        repeat (2) @(negedge clk);
        chk("irq", {63'h0, irq}, 64'h0);
        rd(FESP_OFS_IRQ_STATUS, 16'h0000);
        $display("irq test done");
        mark(2'h3, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("value", program_value, {FESP_RST_OTHER_DATA, FESP_RST_P1_LOW, {2{FESP_RST_OTHER_DATA}}});
        chk("meaning", {61'h0, flag_meaning}, {61'h0, FESP_MEAN_NONE});
        rd(FESP_OFS_STATUS_HIGH, FESP_RST_STATUS_HIGH);
        rd(FESP_OFS_IRQ_STATUS, 16'h0000);
        $display("second reset test done");
        tally_and_finish;
    end
endmodule : tb_fesp_top
bind fesp_top fesp_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .erase_mark, .erase_mark_bank, .erase_mark_sector, .erase_done, .write_error,
    .setup_error, .paused_flag, .write_launch, .program_value, .flag_meaning, .irq);
